//--- core/osc_pkg.sv
// constants for the oscillator stop and clock select block
package osc_pkg;
  localparam logic [2:0] OSC_A_PCC = 3'h0;
  localparam logic [2:0] OSC_A_MCM = 3'h1;
  localparam logic [2:0] OSC_A_RCM = 3'h2;
  localparam logic [2:0] OSC_A_CTL = 3'h3;
  localparam int OSC_B_CPU_PICK = 4;
  localparam int OSC_B_CPU_STAT = 5;
  localparam int OSC_B_MAIN_PICK = 2;
  localparam int OSC_B_MAIN_STAT = 1;
  localparam int OSC_B_MAIN_MODE = 0;
  localparam int OSC_B_HS_STABLE = 7;
  localparam int OSC_B_LS_HALT = 1;
  localparam int OSC_B_HS_HALT = 0;
  localparam int OSC_B_EXT_PICK = 7;
  localparam int OSC_B_OSC_MODE = 6;
  localparam int OSC_B_SUB_EN = 4;
  localparam logic [2:0] OSC_RST_DIV = 3'h1;
  localparam logic [2:0] OSC_DIV_MAX = 3'h4;
  localparam int OSC_CLK_MHZ = 25;
  localparam int OSC_HS_STABLE_US = 2;
  localparam logic [7:0] OSC_HS_STABLE_CYC = 8'(OSC_HS_STABLE_US * OSC_CLK_MHZ);
  typedef enum logic [1:0] {
    OSC_SRC_HS_INT = 2'b00,
    OSC_SRC_XTAL = 2'b01,
    OSC_SRC_EXT = 2'b10,
    OSC_SRC_SUB = 2'b11
  } osc_src_e;
endpackage : osc_pkg

//--- core/osc_clk_ctrl.sv
// register file and clock routing for the oscillator stop and select logic
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module osc_clk_ctrl import osc_pkg::*; (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  // register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // option settings and standby
  input wire logic i_opt_ls_permanent,
  input wire logic i_opt_wdt_enable,
  input wire logic i_stop_mode,
  // oscillator controls
  output logic o_hs_osc_run,
  output logic o_sub_osc_run,
  output logic o_sub_pins_crystal,
  output logic o_ls_osc_run,
  output logic o_ls_to_wdt,
  output logic o_ls_to_timer,
  output logic o_ls_to_lcd,
  // clock routing
  output logic [1:0] o_cpu_src,
  output logic [1:0] o_periph_src,
  output logic o_cpu_sub_half,
  output logic [2:0] o_cpu_div
);
  ////////////////////////////////////////////////////////////////
  logic [2:0] div_q;
  logic cpu_pick_q;
  logic main_pick_q;
  logic main_mode_q;
  logic hs_halt_q;
  logic ls_halt_q;
  logic ext_pick_q;
  logic osc_mode_q;
  logic sub_en_q;
  logic [7:0] stab_q;
  logic [7:0] rdata_q;
  logic [1:0] cpu_src_q;
  logic [1:0] per_src_q;
  logic hs_run_q;
  logic sub_run_q;
  logic ls_run_q;
  logic wdt_q;
  logic div_q_out_sub_q;
  logic [2:0] div_out_q;

  wire wr_pcc = i_wr && (i_addr == OSC_A_PCC);
  wire wr_mcm = i_wr && (i_addr == OSC_A_MCM);
  wire wr_rcm = i_wr && (i_addr == OSC_A_RCM);
  wire wr_ctl = i_wr && (i_addr == OSC_A_CTL);
  // prohibited divider codes are dropped, keeping the last legal one
  wire div_ok = i_wdata[2:0] <= OSC_DIV_MAX;
  wire hs_stable = (stab_q == OSC_HS_STABLE_CYC);
  // status follows the live selection, which settles on the write edge
  wire cpu_on_sub_status = cpu_pick_q;
  wire main_source_status = main_pick_q && main_mode_q;
  wire ls_run_d = i_opt_ls_permanent || !ls_halt_q;

  logic [1:0] per_src_d;
  logic [1:0] cpu_src_d;
  logic [7:0] rd_d;
  assign per_src_d = !main_pick_q ? OSC_SRC_HS_INT :
                     (ext_pick_q ? OSC_SRC_EXT : OSC_SRC_XTAL);
  // low-speed clock is never a cpu source; only the four osc_src_e codes are
  assign cpu_src_d = cpu_pick_q ? OSC_SRC_SUB :
                     (main_source_status ? per_src_d : OSC_SRC_HS_INT);
  assign rd_d = (i_addr == OSC_A_PCC) ? {2'h0, cpu_on_sub_status, cpu_pick_q,
                                          1'h0, div_q} :
                (i_addr == OSC_A_MCM) ? {5'h0, main_pick_q, main_source_status,
                                          main_mode_q} :
                (i_addr == OSC_A_RCM) ? {hs_stable, 5'h0, ls_halt_q, hs_halt_q} :
                (i_addr == OSC_A_CTL) ? {ext_pick_q, osc_mode_q, 1'h0, sub_en_q,
                                          4'h0} :
                8'h00;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      div_q <= OSC_RST_DIV;
      cpu_pick_q <= 1'b0;
      main_pick_q <= 1'b0;
      main_mode_q <= 1'b0;
      hs_halt_q <= 1'b0;
      ls_halt_q <= 1'b0;
      ext_pick_q <= 1'b0;
      osc_mode_q <= 1'b0;
      sub_en_q <= 1'b0;
    end else if (i_ce) begin
      if (wr_pcc && div_ok) begin
        div_q <= i_wdata[2:0];
      end
      if (wr_pcc) begin
        cpu_pick_q <= i_wdata[OSC_B_CPU_PICK];
      end
      if (wr_mcm) begin
        main_pick_q <= i_wdata[OSC_B_MAIN_PICK];
        main_mode_q <= i_wdata[OSC_B_MAIN_MODE];
      end
      if (wr_rcm) begin
        hs_halt_q <= i_wdata[OSC_B_HS_HALT];
        ls_halt_q <= i_wdata[OSC_B_LS_HALT];
      end
      if (wr_ctl) begin
        ext_pick_q <= i_wdata[OSC_B_EXT_PICK];
        osc_mode_q <= i_wdata[OSC_B_OSC_MODE];
        sub_en_q <= i_wdata[OSC_B_SUB_EN];
      end
    end
  end

  // models the hs accuracy settle time after each restart
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      stab_q <= 8'h00;
    end else if (i_ce) begin
      if (hs_halt_q || i_stop_mode) begin
        stab_q <= 8'h00;
      end else if (!hs_stable) begin
        stab_q <= stab_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
      cpu_src_q <= OSC_SRC_HS_INT;
      per_src_q <= OSC_SRC_HS_INT;
      hs_run_q <= 1'b0;
      sub_run_q <= 1'b0;
      ls_run_q <= 1'b0;
      wdt_q <= 1'b0;
      div_q_out_sub_q <= 1'b0;
      div_out_q <= OSC_RST_DIV;
    end else if (i_ce) begin
      rdata_q <= i_rd ? rd_d : 8'h00;
      cpu_src_q <= cpu_src_d;
      per_src_q <= per_src_d;
      hs_run_q <= !hs_halt_q && !i_stop_mode;
      sub_run_q <= sub_en_q;
      ls_run_q <= ls_run_d;
      wdt_q <= ls_run_d && i_opt_wdt_enable;
      div_q_out_sub_q <= cpu_pick_q;
      div_out_q <= div_q;
    end
  end

  assign o_rdata = rdata_q;
  assign o_hs_osc_run = hs_run_q;
  assign o_sub_osc_run = sub_run_q;
  assign o_sub_pins_crystal = sub_run_q;
  assign o_ls_osc_run = ls_run_q;
  assign o_ls_to_wdt = wdt_q;
  assign o_ls_to_timer = ls_run_q;
  assign o_ls_to_lcd = ls_run_q;
  assign o_cpu_src = cpu_src_q;
  assign o_periph_src = per_src_q;
  assign o_cpu_sub_half = div_q_out_sub_q;
  assign o_cpu_div = div_out_q;
endmodule : osc_clk_ctrl

//--- tb/osc_clk_ctrl_assertions.sv
// port assertions for the clock control block
`timescale 1ns/1ns
module osc_chk import osc_pkg::*; (
  // clock, reset, bus
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  // outputs watched
  input wire logic o_sub_osc_run,
  input wire logic o_sub_pins_crystal,
  input wire logic o_ls_osc_run,
  input wire logic o_ls_to_timer,
  input wire logic o_ls_to_lcd,
  input wire logic [1:0] o_cpu_src,
  input wire logic [1:0] o_periph_src,
  input wire logic o_cpu_sub_half,
  input wire logic [2:0] o_cpu_div
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // a write lands in the output flops one edge after it is taken, and is sampled at the second
  sequence s_sub_on;
    i_wr && i_addr == OSC_A_CTL && i_wdata[OSC_B_SUB_EN] ##2 1'b1;
  endsequence
  property p_pins; o_sub_pins_crystal == o_sub_osc_run; endproperty
  a_pins: assert property (p_pins) else $error("pin mode");
  property p_sub_on; s_sub_on |-> o_sub_osc_run; endproperty
  a_sub_on: assert property (p_sub_on) else $error("sub on");
  property p_sub_off; $fell(o_sub_osc_run) |-> $past(i_wr, 2); endproperty
  a_sub_off: assert property (p_sub_off) else $error("sub off");
  property p_ls; o_ls_to_timer == o_ls_osc_run && o_ls_to_lcd == o_ls_osc_run; endproperty
  a_ls: assert property (p_ls) else $error("ls route");
  property p_periph; o_periph_src != OSC_SRC_SUB; endproperty
  a_periph: assert property (p_periph) else $error("periph src");
  property p_half; o_cpu_sub_half == (o_cpu_src == OSC_SRC_SUB); endproperty
  a_half: assert property (p_half) else $error("cpu half");
  property p_div; o_cpu_div <= OSC_DIV_MAX; endproperty
  a_div: assert property (p_div) else $error("div code");
  property p_rst;
    $fell(i_rst) |-> !o_sub_osc_run && o_cpu_src == OSC_SRC_HS_INT && o_cpu_div == OSC_RST_DIV;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule : osc_chk

//--- tb/osc_clk_ctrl_tb.sv
// testbench for the clock control block
`timescale 1ns/1ns
module osc_clk_ctrl_tb import osc_pkg::*;;
  logic i_clk_sys = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_stop_mode = 0;
  logic i_opt_ls_permanent = 0, i_opt_wdt_enable = 1;
  logic [2:0] i_addr = 0, o_cpu_div;
  logic [7:0] i_wdata = 0, o_rdata, r;
  logic o_hs_osc_run, o_sub_osc_run, o_sub_pins_crystal, o_ls_osc_run, o_ls_to_wdt;
  logic o_ls_to_timer, o_ls_to_lcd, o_cpu_sub_half;
  logic [1:0] o_cpu_src, o_periph_src, p;
  int err_count = 0, n_checks = 0;
  osc_clk_ctrl u_osc_clk_ctrl (.i_clk_sys, .i_rst, .i_ce(1'b1), .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_opt_ls_permanent, .i_opt_wdt_enable, .i_stop_mode, .o_hs_osc_run,
    .o_sub_osc_run, .o_sub_pins_crystal, .o_ls_osc_run, .o_ls_to_wdt, .o_ls_to_timer,
    .o_ls_to_lcd, .o_cpu_src, .o_periph_src, .o_cpu_sub_half, .o_cpu_div);
  always #20 i_clk_sys = ~i_clk_sys;
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 r = o_rdata;
  endtask : rd
  // one more edge moves register state into the output flops
  task st;
    @(posedge i_clk_sys);
    #1;
  endtask : st
  task t_src;
    for (int i = 0; i < 16; i++) begin
      p = i[1] ? {i[3], !i[3]} : 2'b00;
      wr(OSC_A_CTL, {i[3], 7'h00});
      wr(OSC_A_MCM, {5'h00, i[1], 1'b0, i[0]});
      wr(OSC_A_PCC, {3'h0, i[2], 4'h1});
      st;
      chk({3'h0, o_cpu_sub_half, o_cpu_src, o_periph_src},
        {3'h0, i[2], i[2] ? 2'b11 : (i[1] & i[0]) ? p : 2'b00, p});
      rd(OSC_A_PCC);
      chk(r & 8'h20, {2'h0, i[2], 5'h00});
      rd(OSC_A_MCM);
      chk(r & 8'h02, {6'h00, i[1] & i[0], 1'b0});
    end
  endtask : t_src
  task t_div;
    logic [2:0] e;
    e = 3'h1;
    // codes above the table must leave the old divider in place
    for (int d = 7; d >= 0; d--) begin
      wr(OSC_A_PCC, {5'h00, d[2:0]});
      if (d <= 4) e = d[2:0];
      st;
      chk({5'h00, o_cpu_div}, {5'h00, e});
    end
  endtask : t_div
  task t_osc;
    // cpu already runs from the external clock here, so halting hs is legal
    wr(OSC_A_RCM, 8'h01);
    st;
    chk({7'h00, o_hs_osc_run}, 8'h00);
    rd(OSC_A_RCM);
    chk(r, 8'h01);
    wr(OSC_A_RCM, 8'h02);
    repeat (60) @(posedge i_clk_sys);
    rd(OSC_A_RCM);
    chk(r, 8'h82);
    chk({5'h00, o_hs_osc_run, o_ls_osc_run, o_ls_to_timer}, 8'h04);
    @(posedge i_clk_sys);
    i_opt_ls_permanent <= 1'b1;
    st;
    chk({6'h00, o_ls_osc_run, o_ls_to_wdt}, 8'h03);
    i_opt_ls_permanent <= 1'b0;
    i_opt_wdt_enable <= 1'b0;
    wr(OSC_A_RCM, 8'h00);
    st;
    chk({6'h00, o_ls_osc_run, o_ls_to_wdt}, 8'h02);
    wr(OSC_A_CTL, 8'h10);
    // no hardware ready flag for the sub oscillator, so software just waits
    repeat (4) @(posedge i_clk_sys);
    st;
    chk({6'h00, o_sub_osc_run, o_sub_pins_crystal}, 8'h03);
    @(posedge i_clk_sys);
    i_stop_mode <= 1'b1;
    st;
    chk({6'h00, o_hs_osc_run, o_sub_osc_run}, 8'h01);
    i_stop_mode <= 1'b0;
    // cpu is not on the sub clock, so clearing the enable is allowed
    wr(OSC_A_CTL, 8'h00);
    st;
    chk({7'h00, o_sub_osc_run}, 8'h00);
    rd(3'h5);
    chk(r, 8'h00);
  endtask : t_osc
  task conclude;
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk({o_cpu_src, o_periph_src, o_sub_osc_run, o_cpu_div}, 8'h01);
    chk({6'h00, o_ls_osc_run, o_hs_osc_run}, 8'h03);
    t_src;
    t_div;
    t_osc;
    conclude;
  end
endmodule : osc_clk_ctrl_tb
bind osc_clk_ctrl osc_chk u_osc_chk (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr,
  .o_sub_osc_run, .o_sub_pins_crystal, .o_ls_osc_run, .o_ls_to_timer, .o_ls_to_lcd,
  .o_cpu_src, .o_periph_src, .o_cpu_sub_half, .o_cpu_div);
